/* design/motor_capture_compare_timer.sv */
// Motor control capture and compare timer with an APB register slave.
//
// Chosen here: the APB slave port and the placing of the registers.
`default_nettype none
module motor_capture_compare_timer (
	input  wire logic        sys_clk,            // System clock, 100 MHz
	input  wire logic        reset_n,            // Synchronous reset, active low
	input  wire logic        clk_en,             // Freezes all state while low
	input  wire logic        psel,               // APB select
	input  wire logic        penable,            // APB enable
	input  wire logic        pwrite,             // APB write
	input  wire logic [7:0]  paddr,              // APB byte address
	input  wire logic [31:0] pwdata,             // APB write data
	input  wire logic        hall_input_a,       // Hall input a pin
	input  wire logic        hall_input_b,       // Hall input b pin
	input  wire logic        hall_input_c,       // Hall input c pin
	input  wire logic        aux_trigger_input,  // Auxiliary trigger pin
	input  wire logic        pwm_period_signal,  // PWM period signal
	output logic      [31:0] prdata,             // APB read data
	output logic             pready,             // APB ready
	output logic             pslverr,            // APB error on unmapped address
	output logic             irq,                // Interrupt request
	output logic             compare_match       // Counter equals compare value
);
	logic [7:0]  timer_control_0;
	logic [7:0]  timer_control_1;
	logic [15:0] count;
	logic [15:0] compare;
	logic [15:0] captured;
	logic        trigger_event_flag;
	logic        match_event_flag;
	logic        trigger_irq_enable;
	logic        match_irq_enable;
	logic [motor_timer_pkg::IN_SYNC_W-1:0] sync_1;
	logic [motor_timer_pkg::IN_SYNC_W-1:0] sync_2;
	logic [motor_timer_pkg::PRESC_W-1:0]   presc;
	logic [1:0]  filt_clk;
	logic [3:0]  hist;
	logic        filt;
	logic        trig_prev;
	logic        pwm_prev;
	logic        timer_on_d;

	// Two-stage synchronisers for every pin input.
	wire [motor_timer_pkg::IN_SYNC_W-1:0] raw_in = {pwm_period_signal, aux_trigger_input,
		hall_input_c, hall_input_b, hall_input_a};
	genvar gi;
	generate
		for (gi = 0; gi < motor_timer_pkg::IN_SYNC_W; gi++) begin : g_sync
			always_ff @(posedge sys_clk) begin
				if (!reset_n) begin
					sync_1[gi] <= 1'b0;
					sync_2[gi] <= 1'b0;
				end else if (clk_en) begin
					sync_1[gi] <= raw_in[gi];
					sync_2[gi] <= sync_1[gi];
				end
			end
		end
	endgenerate
	wire filtered_hall_a = sync_2[0];
	wire filtered_hall_b = sync_2[1];
	wire filtered_hall_c = sync_2[2];
	wire aux_sync        = sync_2[3];
	wire pwm_sync        = sync_2[4];

	// Control fields.
	wire       count_pause                = timer_control_0[motor_timer_pkg::PAUSE_BIT];
	wire [2:0] count_clock_select         = timer_control_0[motor_timer_pkg::CLK_SEL_LSB +: 3];
	wire       timer_on                   = timer_control_0[motor_timer_pkg::TIMER_ON_BIT];
	wire [1:0] trigger_source_select      = timer_control_0[motor_timer_pkg::SRC_SEL_LSB +: 2];
	wire [1:0] trigger_edge_select        = timer_control_1[motor_timer_pkg::EDGE_SEL_LSB +: 2];
	wire       trigger_input_enable       = timer_control_1[motor_timer_pkg::TRIG_EN_BIT];
	wire       filter_sample_count        = timer_control_1[motor_timer_pkg::FILT_CNT_BIT];
	wire       filter_sample_clock_select = timer_control_1[motor_timer_pkg::FILT_CLK_BIT];
	wire       filter_enable              = timer_control_1[motor_timer_pkg::FILT_EN_BIT];
	wire       clear_on_trigger           = timer_control_1[motor_timer_pkg::CLR_TRIG_BIT];
	wire       clear_on_match             = timer_control_1[motor_timer_pkg::CLR_MATCH_BIT];

	// Count clock: a divide by 2**code is a tick when the low code bits of the prescaler are all ones.
	wire [7:0] presc_mask_w = (8'h01 << count_clock_select) - 8'h01;
	wire [motor_timer_pkg::PRESC_W-1:0] presc_mask = presc_mask_w[motor_timer_pkg::PRESC_W-1:0];
	wire presc_tick = (presc & presc_mask) == presc_mask;
	wire pwm_rise   = pwm_sync & ~pwm_prev;
	wire count_tick = (count_clock_select == motor_timer_pkg::CLK_SEL_PWM) ?
		pwm_rise : presc_tick;

	// Trigger source selection.
	wire sel_in = (trigger_source_select == 2'h0) ? filtered_hall_a :
		(trigger_source_select == 2'h1) ? filtered_hall_b :
		(trigger_source_select == 2'h2) ? filtered_hall_c : aux_sync;

	// Noise filter sampling and acceptance.
	wire sample_tick = filter_sample_clock_select ?
		(filt_clk == motor_timer_pkg::FILT_SLOW_LAST) : 1'b1;
	wire hist_same = filter_sample_count ?
		((hist == 4'hF) || (hist == 4'h0)) :
		((hist[1:0] == 2'h3) || (hist[1:0] == 2'h0));
	wire trig_sig = filter_enable ? filt : sel_in;

	// Edge detection and capture qualification.
	wire trig_rise = trig_sig & ~trig_prev;
	wire trig_fall = ~trig_sig & trig_prev;
	wire edge_hit  = (trigger_edge_select == motor_timer_pkg::EDGE_RISE) ? trig_rise :
		(trigger_edge_select == motor_timer_pkg::EDGE_FALL) ? trig_fall :
		(trigger_edge_select == motor_timer_pkg::EDGE_BOTH) ? (trig_rise | trig_fall) :
		1'b0;
	wire capture_evt = timer_on & trigger_input_enable & edge_hit;

	// Compare and counter control.
	wire match_now = (count == compare);
	wire match_evt = timer_on & match_now & ~compare_match;
	wire on_rise   = timer_on & ~timer_on_d;
	wire clr_trig  = capture_evt & clear_on_trigger;
	wire clr_match = match_now & clear_on_match;
	wire [15:0] count_inc = count + 16'h0001;
	wire [15:0] next_count = on_rise ? motor_timer_pkg::WORD_RESET :
		!timer_on ? count :
		clr_trig ? motor_timer_pkg::WORD_RESET :
		clr_match ? motor_timer_pkg::WORD_RESET :
		(!count_pause && count_tick) ? count_inc : count;

	// APB decode: one wait state, write lands at the completing edge.
	wire access     = psel & penable & ~pready;
	wire done       = psel & penable & pready;
	wire wr_fire    = done & pwrite;
	wire hit_ctl0   = (paddr == motor_timer_pkg::OFS_CONTROL_0);
	wire hit_ctl1   = (paddr == motor_timer_pkg::OFS_CONTROL_1);
	wire hit_cnt_lo = (paddr == motor_timer_pkg::OFS_COUNT_LO);
	wire hit_cnt_hi = (paddr == motor_timer_pkg::OFS_COUNT_HI);
	wire hit_cmp_lo = (paddr == motor_timer_pkg::OFS_CMP_LO);
	wire hit_cmp_hi = (paddr == motor_timer_pkg::OFS_CMP_HI);
	wire hit_cap_lo = (paddr == motor_timer_pkg::OFS_CAP_LO);
	wire hit_cap_hi = (paddr == motor_timer_pkg::OFS_CAP_HI);
	wire hit_stat   = (paddr == motor_timer_pkg::OFS_STATUS);
	wire hit_irq_en = (paddr == motor_timer_pkg::OFS_IRQ_EN);
	wire mapped = hit_ctl0 | hit_ctl1 | hit_cnt_lo | hit_cnt_hi | hit_cmp_lo | hit_cmp_hi |
		hit_cap_lo | hit_cap_hi | hit_stat | hit_irq_en;
	wire [7:0] status_rd = {6'h00, match_event_flag, trigger_event_flag};
	wire [7:0] irq_en_rd = {6'h00, match_irq_enable, trigger_irq_enable};
	wire [7:0] rd_mux = hit_ctl0 ? timer_control_0 :
		hit_ctl1 ? timer_control_1 :
		hit_cnt_lo ? count[7:0] :
		hit_cnt_hi ? count[15:8] :
		hit_cmp_lo ? compare[7:0] :
		hit_cmp_hi ? compare[15:8] :
		hit_cap_lo ? captured[7:0] :
		hit_cap_hi ? captured[15:8] :
		hit_stat ? status_rd :
		hit_irq_en ? irq_en_rd : 8'h00;
	wire clr_trig_flag  = wr_fire & hit_stat & pwdata[motor_timer_pkg::TRIG_FLAG_BIT];
	wire clr_match_flag = wr_fire & hit_stat & pwdata[motor_timer_pkg::MATCH_FLAG_BIT];
	// A new event in the cycle of its clear wins over the clear.
	wire next_trig_flag  = (trigger_event_flag & ~clr_trig_flag) | capture_evt;
	wire next_match_flag = (match_event_flag & ~clr_match_flag) | match_evt;
	wire next_irq = (next_trig_flag & trigger_irq_enable) |
		(next_match_flag & match_irq_enable);

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (clk_en) begin
			pready  <= access;
			pslverr <= access & ~mapped;
			prdata  <= (access & ~pwrite) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			timer_control_0    <= motor_timer_pkg::BYTE_RESET;
			timer_control_1    <= motor_timer_pkg::BYTE_RESET;
			compare            <= motor_timer_pkg::WORD_RESET;
			trigger_irq_enable <= 1'b0;
			match_irq_enable   <= 1'b0;
		end else if (clk_en && wr_fire) begin
			if (hit_ctl0) begin
				timer_control_0 <= pwdata[7:0] & motor_timer_pkg::CONTROL_0_MASK;
			end
			if (hit_ctl1) begin
				timer_control_1 <= pwdata[7:0];
			end
			if (hit_cmp_lo) begin
				compare[7:0] <= pwdata[7:0];
			end
			if (hit_cmp_hi) begin
				compare[15:8] <= pwdata[7:0];
			end
			if (hit_irq_en) begin
				trigger_irq_enable <= pwdata[motor_timer_pkg::TRIG_FLAG_BIT];
				match_irq_enable   <= pwdata[motor_timer_pkg::MATCH_FLAG_BIT];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			presc     <= '0;
			filt_clk  <= 2'h0;
			hist      <= 4'h0;
			filt      <= 1'b0;
			trig_prev <= 1'b0;
			pwm_prev  <= 1'b0;
		end else if (clk_en) begin
			presc     <= presc + 1'b1;
			filt_clk  <= filt_clk + 2'h1;
			if (sample_tick) begin
				hist <= {hist[2:0], sel_in};
			end
			if (hist_same) begin
				filt <= hist[0];
			end
			trig_prev <= trig_sig;
			pwm_prev  <= pwm_sync;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			count              <= motor_timer_pkg::WORD_RESET;
			captured           <= motor_timer_pkg::WORD_RESET;
			timer_on_d         <= 1'b0;
			compare_match      <= 1'b0;
			trigger_event_flag <= 1'b0;
			match_event_flag   <= 1'b0;
			irq                <= 1'b0;
		end else if (clk_en) begin
			count              <= next_count;
			timer_on_d         <= timer_on;
			compare_match      <= match_now;
			trigger_event_flag <= next_trig_flag;
			match_event_flag   <= next_match_flag;
			irq                <= next_irq;
			if (capture_evt) begin
				captured <= count;
			end
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	property p_clk_tick;
		(clk_en && count_clock_select == 3'h1 && presc_tick)
			|=> !(clk_en && count_clock_select == 3'h1 && presc_tick);
	endproperty
	a_clk_tick: assert property (p_clk_tick) else $error("divide by two ticks twice");

	property p_plain_count;
		(clk_en && timer_on && timer_on_d && !count_pause && count_tick && !clr_trig &&
			!clr_match) |=> (count == $past(count) + 16'h0001);
	endproperty
	a_plain_count: assert property (p_plain_count) else $error("count did not advance");

	property p_pause_hold;
		(clk_en && timer_on && timer_on_d && count_pause && !clr_trig && !clr_match)
			|=> $stable(count);
	endproperty
	a_pause_hold: assert property (p_pause_hold) else $error("paused count moved");

	property p_on_clear;
		(clk_en && on_rise) |=> (count == 16'h0000);
	endproperty
	a_on_clear: assert property (p_on_clear) else $error("count not cleared on start");

	property p_off_hold;
		(clk_en && !timer_on) |=> $stable(count);
	endproperty
	a_off_hold: assert property (p_off_hold) else $error("count moved while off");

	property p_edge_off;
		(trigger_edge_select == motor_timer_pkg::EDGE_NONE || !trigger_input_enable)
			|-> !capture_evt;
	endproperty
	a_edge_off: assert property (p_edge_off) else $error("capture while disabled");

	property p_bypass;
		(!filter_enable && trigger_source_select == 2'h3) |-> (trig_sig == aux_sync);
	endproperty
	a_bypass: assert property (p_bypass) else $error("filter not bypassed");

	property p_capture_copy;
		(clk_en && capture_evt) |=> (captured == $past(count)) && trigger_event_flag;
	endproperty
	a_capture_copy: assert property (p_capture_copy) else $error("capture lost");

	property p_capture_clear;
		(clk_en && capture_evt && clear_on_trigger && timer_on_d) |=> (count == 16'h0000);
	endproperty
	a_capture_clear: assert property (p_capture_clear) else $error("no clear on trigger");

	property p_match_clear;
		(clk_en && timer_on && timer_on_d && match_now && clear_on_match)
			|=> (count == 16'h0000) && compare_match;
	endproperty
	a_match_clear: assert property (p_match_clear) else $error("no clear on match");

	property p_wrap;
		(clk_en && timer_on && timer_on_d && !count_pause && count_tick &&
			count == motor_timer_pkg::COUNT_MAX) |=> (count == 16'h0000);
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter did not wrap");

	property p_count_read;
		(clk_en && access && !pwrite && hit_cnt_lo) |=> pready && (prdata[7:0] == $past(count[7:0]));
	endproperty
	a_count_read: assert property (p_count_read) else $error("count read wrong");

	property p_match_flag;
		(clk_en && match_evt) |=> match_event_flag;
	endproperty
	a_match_flag: assert property (p_match_flag) else $error("match flag not set");

	property p_match_detect;
		(clk_en && match_now) |=> compare_match;
	endproperty
	a_match_detect: assert property (p_match_detect) else $error("match missing");

	property p_trig_flag_clear;
		(clk_en && clr_trig_flag && !capture_evt) |=> !trigger_event_flag;
	endproperty
	a_trig_flag_clear: assert property (p_trig_flag_clear) else $error("flag kept");

	property p_irq_raise;
		($past(clk_en) && trigger_event_flag && trigger_irq_enable && $stable(trigger_irq_enable))
			|-> irq;
	endproperty
	a_irq_raise: assert property (p_irq_raise) else $error("interrupt not raised");

	property p_filter_hold;
		(clk_en && !hist_same) |=> $stable(filt);
	endproperty
	a_filter_hold: assert property (p_filter_hold) else $error("filter moved early");

	property p_filter_accept;
		(clk_en && hist == 4'hF) |=> filt;
	endproperty
	a_filter_accept: assert property (p_filter_accept) else $error("level missed");

	property p_sample_slow;
		(clk_en && filter_sample_clock_select && filt_clk != motor_timer_pkg::FILT_SLOW_LAST)
			|=> $stable(hist);
	endproperty
	a_sample_slow: assert property (p_sample_slow) else $error("sampled off tick");

	property p_ready_pulse;
		(clk_en && pready) |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

	property p_unmapped;
		(clk_en && access && !mapped) |=> pready && pslverr;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("no error on unmapped address");

	c_capture:   cover property (clk_en && capture_evt && clear_on_trigger);
	c_match:     cover property (clk_en && match_evt && clear_on_match);
	c_filtered:  cover property (clk_en && filter_enable && filter_sample_count && capture_evt);
	c_wrap:      cover property (clk_en && count == motor_timer_pkg::COUNT_MAX && count_tick);
endmodule
`default_nettype wire

/* shared/motor_timer_pkg.sv */
// Register map, field positions, reset values and widths of the motor timer.
`default_nettype none
package motor_timer_pkg;
	localparam int          ADDR_W        = 8;
	localparam logic [7:0]  OFS_CONTROL_0 = 8'h00;
	localparam logic [7:0]  OFS_CONTROL_1 = 8'h04;
	localparam logic [7:0]  OFS_COUNT_LO  = 8'h08;
	localparam logic [7:0]  OFS_COUNT_HI  = 8'h0C;
	localparam logic [7:0]  OFS_CMP_LO    = 8'h10;
	localparam logic [7:0]  OFS_CMP_HI    = 8'h14;
	localparam logic [7:0]  OFS_CAP_LO    = 8'h18;
	localparam logic [7:0]  OFS_CAP_HI    = 8'h1C;
	localparam logic [7:0]  OFS_STATUS    = 8'h20;
	localparam logic [7:0]  OFS_IRQ_EN    = 8'h24;
	// Control 0 fields.
	localparam int          PAUSE_BIT     = 7;
	localparam int          CLK_SEL_LSB   = 4;
	localparam int          TIMER_ON_BIT  = 3;
	localparam int          SRC_SEL_LSB   = 0;
	localparam logic [7:0]  CONTROL_0_MASK = 8'hFB;
	// Control 1 fields.
	localparam int          EDGE_SEL_LSB  = 6;
	localparam int          TRIG_EN_BIT   = 5;
	localparam int          FILT_CNT_BIT  = 4;
	localparam int          FILT_CLK_BIT  = 3;
	localparam int          FILT_EN_BIT   = 2;
	localparam int          CLR_TRIG_BIT  = 1;
	localparam int          CLR_MATCH_BIT = 0;
	// Status and interrupt enable fields.
	localparam int          TRIG_FLAG_BIT  = 0;
	localparam int          MATCH_FLAG_BIT = 1;
	// Encodings.
	localparam logic [2:0]  CLK_SEL_PWM   = 3'h0;
	localparam logic [1:0]  EDGE_NONE     = 2'h0;
	localparam logic [1:0]  EDGE_RISE     = 2'h1;
	localparam logic [1:0]  EDGE_FALL     = 2'h2;
	localparam logic [1:0]  EDGE_BOTH     = 2'h3;
	// Reset values and widths.
	localparam logic [7:0]  BYTE_RESET    = 8'h00;
	localparam logic [15:0] WORD_RESET    = 16'h0000;
	localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
	localparam int          PRESC_W       = 7;
	localparam int          IN_SYNC_W     = 5;
	localparam logic [1:0]  FILT_SLOW_LAST = 2'h3;
endpackage
`default_nettype wire

/* sim/hall_pwm_model.sv */
// Far-side model: hall sensor pins, auxiliary trigger pin and PWM period signal.
`default_nettype none
module hall_pwm_model #(
	parameter int PWM_HIGH = 2, // Cycles high per PWM period pulse
	parameter int PWM_LOW  = 3  // One less than the cycles low between PWM pulses
) (
	input  wire logic sys_clk,           // System clock
	output logic      hall_input_a,      // Hall input a
	output logic      hall_input_b,      // Hall input b
	output logic      hall_input_c,      // Hall input c
	output logic      aux_trigger_input, // Auxiliary trigger input
	output logic      pwm_period_signal  // PWM period signal
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] pins = 4'h0;
	assign hall_input_a      = pins[0];
	assign hall_input_b      = pins[1];
	assign hall_input_c      = pins[2];
	assign aux_trigger_input = pins[3];
	initial pwm_period_signal = 1'b0;
	task automatic set_pin(input int idx, input logic lvl);
		@(posedge sys_clk);
		pins[idx] <= lvl;
	endtask
	// Holds the pin high for exactly width clock cycles.
	task automatic pin_pulse(input int idx, input int width);
		set_pin(idx, 1'b1);
		repeat (width - 1) @(posedge sys_clk);
		set_pin(idx, 1'b0);
	endtask
	task automatic pwm_pulses(input int n);
		repeat (n) begin
			@(posedge sys_clk);
			pwm_period_signal <= 1'b1;
			repeat (PWM_HIGH) @(posedge sys_clk);
			pwm_period_signal <= 1'b0;
			repeat (PWM_LOW) @(posedge sys_clk);
		end
	endtask
endmodule
`default_nettype wire

/* sim/motor_capture_compare_timer_tb.sv */
// Self-checking bench for the motor capture and compare timer over APB.
`default_nettype none
module motor_capture_compare_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [47:0] FCTL = 48'h60_64_64_74_7C_7C;
	localparam logic [47:0] FW   = 48'h01_04_01_08_18_08;
	localparam logic [5:0]  FEXP = 6'b110110;
	localparam logic [11:0] EDGES = 12'b01_00_11_11_10_01;
	logic        sys_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        clk_en  = 1'b1;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h00000000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic        compare_match;
	logic        hall_a;
	logic        hall_b;
	logic        hall_c;
	logic        aux_in;
	logic        pwm_sig;
	logic [31:0] rd;
	logic        err;
	int          n_mismatch = 0;
	int          checks     = 0;
	always #5 sys_clk = ~sys_clk;
	motor_capture_compare_timer dut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.hall_input_a(hall_a), .hall_input_b(hall_b), .hall_input_c(hall_c),
		.aux_trigger_input(aux_in), .pwm_period_signal(pwm_sig), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .compare_match(compare_match));
	hall_pwm_model far (.sys_clk(sys_clk), .hall_input_a(hall_a), .hall_input_b(hall_b),
		.hall_input_c(hall_c), .aux_trigger_input(aux_in), .pwm_period_signal(pwm_sig));
	task automatic results();
		$display("Checks %0d, mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// One APB transfer; the request is held until pready is sampled high.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic in_range(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
		checks++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask
	initial begin
		#200000;
		n_mismatch++;
		results();
	end
	initial begin
		logic [31:0] v;
		logic [1:0]  e;
		logic        rc;
		logic        fc;
		repeat (6) @(posedge sys_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 10; i++) rchk(8'(i * 4), 32'h0);
		wr(motor_timer_pkg::OFS_CONTROL_0, 8'hFF);
		rchk(motor_timer_pkg::OFS_CONTROL_0, 32'hFB);
		wr(motor_timer_pkg::OFS_CONTROL_1, 8'hFF);
		rchk(motor_timer_pkg::OFS_CONTROL_1, 32'hFF);
		wr(motor_timer_pkg::OFS_CMP_LO, 8'hA5);
		wr(motor_timer_pkg::OFS_CMP_HI, 8'h5A);
		rchk(motor_timer_pkg::OFS_CMP_LO, 32'hA5);
		rchk(motor_timer_pkg::OFS_CMP_HI, 32'h5A);
		wr(motor_timer_pkg::OFS_COUNT_LO, 8'h77);
		rchk(motor_timer_pkg::OFS_COUNT_LO, 32'h0);
		wr(motor_timer_pkg::OFS_CAP_HI, 8'h77);
		rchk(motor_timer_pkg::OFS_CAP_HI, 32'h0);
		apb(1'b1, 8'h28, 32'h1);
		chk({31'h0, err}, 32'h1);
		wr(motor_timer_pkg::OFS_CONTROL_1, 8'h00);
		for (int n = 1; n < 8; n++) begin
			wr(motor_timer_pkg::OFS_CONTROL_0, 8'h00);
			wr(motor_timer_pkg::OFS_CONTROL_0, {1'b0, 3'(n), 4'h8});
			repeat (8 << n) @(posedge sys_clk);
			apb(1'b0, motor_timer_pkg::OFS_COUNT_LO, 32'h0);
			in_range(rd, 7, 10);
		end
		wr(motor_timer_pkg::OFS_CONTROL_0, 8'hF8);
		apb(1'b0, motor_timer_pkg::OFS_COUNT_LO, 32'h0);
		v = rd;
		repeat (300) @(posedge sys_clk);
		rchk(motor_timer_pkg::OFS_COUNT_LO, v);
		wr(motor_timer_pkg::OFS_CONTROL_0, 8'h78);
		repeat (1280) @(posedge sys_clk);
		apb(1'b0, motor_timer_pkg::OFS_COUNT_LO, 32'h0);
		in_range(rd, v + 9, v + 11);
		wr(motor_timer_pkg::OFS_CONTROL_0, 8'h70);
		apb(1'b0, motor_timer_pkg::OFS_COUNT_LO, 32'h0);
		v = rd;
		repeat (300) @(posedge sys_clk);
		rchk(motor_timer_pkg::OFS_COUNT_LO, v);
		in_range(v, 1, 255);
		wr(motor_timer_pkg::OFS_CONTROL_0, 8'h78);
		apb(1'b0, motor_timer_pkg::OFS_COUNT_LO, 32'h0);
		in_range(rd, 0, 1);
		// Compare at 3 with PWM ticks, first without and then with clear on match.
		wr(motor_timer_pkg::OFS_CONTROL_0, 8'h00);
		wr(motor_timer_pkg::OFS_CONTROL_0, 8'h08);
		wr(motor_timer_pkg::OFS_CMP_LO, 8'h03);
		wr(motor_timer_pkg::OFS_CMP_HI, 8'h00);
		wr(motor_timer_pkg::OFS_STATUS, 8'h03);
		far.pwm_pulses(3);
		repeat (6) @(posedge sys_clk);
		chk({31'h0, compare_match}, 32'h1);
		rchk(motor_timer_pkg::OFS_STATUS, 32'h2);
		far.pwm_pulses(1);
		repeat (6) @(posedge sys_clk);
		chk({31'h0, compare_match}, 32'h0);
		rchk(motor_timer_pkg::OFS_COUNT_LO, 32'h4);
		// A low clock enable must swallow PWM edges and freeze the count.
		@(posedge sys_clk);
		clk_en <= 1'b0;
		far.pwm_pulses(2);
		clk_en <= 1'b1;
		rchk(motor_timer_pkg::OFS_COUNT_LO, 32'h4);
		wr(motor_timer_pkg::OFS_CONTROL_1, 8'h01);
		wr(motor_timer_pkg::OFS_CONTROL_0, 8'h00);
		wr(motor_timer_pkg::OFS_CONTROL_0, 8'h08);
		far.pwm_pulses(5);
		repeat (6) @(posedge sys_clk);
		rchk(motor_timer_pkg::OFS_COUNT_LO, 32'h2);
		// Capture table: source, edge, enable and clear on trigger per step.
		wr(motor_timer_pkg::OFS_CMP_HI, 8'hFF);
		wr(motor_timer_pkg::OFS_IRQ_EN, 8'h01);
		for (int k = 0; k < 6; k++) begin
			e  = EDGES[2 * k +: 2];
			rc = (k != 5) && e[0];
			fc = (k != 5) && e[1];
			wr(motor_timer_pkg::OFS_STATUS, 8'h03);
			wr(motor_timer_pkg::OFS_CONTROL_1, {e, 1'(k != 5), 3'h0, 1'(k != 3), 1'b0});
			wr(motor_timer_pkg::OFS_CONTROL_0, {6'h00, 2'(k % 4)});
			wr(motor_timer_pkg::OFS_CONTROL_0, {6'h02, 2'(k % 4)});
			far.pwm_pulses(k + 2);
			far.set_pin(k % 4, 1'b1);
			repeat (8) @(posedge sys_clk);
			chk({31'h0, irq}, {31'h0, rc});
			rchk(motor_timer_pkg::OFS_STATUS, {31'h0, rc});
			if (rc) rchk(motor_timer_pkg::OFS_CAP_LO, k + 2);
			wr(motor_timer_pkg::OFS_STATUS, 8'h03);
			far.pwm_pulses(1);
			far.set_pin(k % 4, 1'b0);
			repeat (8) @(posedge sys_clk);
			rchk(motor_timer_pkg::OFS_STATUS, {31'h0, fc});
			if (fc) rchk(motor_timer_pkg::OFS_CAP_LO, (rc && k != 3) ? 1 : k + 3);
			rchk(motor_timer_pkg::OFS_COUNT_LO, (fc && k != 3) ? 0 : (rc && k != 3) ? 1 : k + 3);
		end
		// Filter table: sample count, sample clock and bypass against pulse widths.
		wr(motor_timer_pkg::OFS_CONTROL_0, 8'h08);
		for (int k = 0; k < 6; k++) begin
			wr(motor_timer_pkg::OFS_STATUS, 8'h03);
			wr(motor_timer_pkg::OFS_CONTROL_1, FCTL[8 * k +: 8]);
			repeat (20) @(posedge sys_clk);
			far.pin_pulse(0, int'(FW[8 * k +: 8]));
			repeat (30) @(posedge sys_clk);
			rchk(motor_timer_pkg::OFS_STATUS, {31'h0, FEXP[k]});
		end
		results();
	end
endmodule
`default_nettype wire
